// >>> testbench/lcd_host_model.sv
// Host processor model on the decoder's parallel and I2C inputs
module lcd_host_model (
  input  wire logic       clk,
  input  wire logic       wr_ready,
  output logic            wr_valid,
  output logic            register_select,
  output logic [7:0]      wr_data,
  output logic            i2c_byte_valid,
  output logic [7:0]      i2c_byte,
  output logic            i2c_start,
  output logic            rd_req,
  output logic            rd_select,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_valid = 1'b0;
    register_select = 1'b0;
    wr_data = 8'h00;
    i2c_byte_valid = 1'b0;
    i2c_byte = 8'h00;
    i2c_start = 1'b0;
    rd_req = 1'b0;
    rd_select = 1'b0;
  end

  // Parallel byte to instruction or data holding register
  task automatic put(input logic rs, input logic [7:0] d);
    @(negedge clk);
    while (wr_ready !== 1'b1) @(negedge clk);
    wr_valid = 1'b1;
    register_select = rs;
    wr_data = d;
    @(negedge clk);
    wr_valid = 1'b0;
    register_select = ~rs;
    wr_data = ~d;
  endtask

  // Status or data read
  task automatic read(input logic sel, output logic [7:0] d,
                      output logic ok);
    @(negedge clk);
    rd_req = 1'b1;
    rd_select = sel;
    @(negedge clk);
    rd_req = 1'b0;
    rd_select = ~sel;
    ok = rd_valid;
    d = rd_data;
  endtask

  // Poll status until idle
  task automatic poll_idle();
    logic [7:0] s;
    logic       ok;
    int         k;
    k = 0;
    s = 8'hff;
    while (s[7] !== 1'b0 && k < 400) begin
      read(1'b0, s, ok);
      k++;
    end
  endtask

  // Start condition pulse only, no address byte sent
  task automatic i2c_begin();
    @(negedge clk);
    i2c_start = 1'b1;
    @(negedge clk);
    i2c_start = 1'b0;
  endtask

  task automatic i2c_put(input logic [7:0] b);
    @(negedge clk);
    i2c_byte_valid = 1'b1;
    i2c_byte = b;
    @(negedge clk);
    i2c_byte_valid = 1'b0;
    i2c_byte = ~b;
  endtask

  // Control byte then payload
  task automatic i2c_cmd(input logic more, input logic rs,
                         input logic [7:0] d);
    i2c_put({more, rs, 6'h00});
    i2c_put(d);
  endtask
endmodule

// >>> testbench/lcd_instruction_decoder_tb_top.sv
// Self-checking bench for the LCD instruction decoder
module lcd_instruction_decoder_tb_top;
  import lcd_decoder_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, reset, wr_valid, register_select, wr_ready;
  logic       i2c_byte_valid, i2c_start, rd_req, rd_select, rd_valid;
  logic       busy_flag, interface_width_select, two_line_mode;
  logic       multiplex_ratio_select, extended_page, increment_dir;
  logic       shift_on_access, display_on, cursor_on, cursor_blink;
  logic       power_down, temp_coefficient_low, temp_coefficient_high;
  logic       pump_stage_high, pump_stage_low, mirror_screen;
  logic       column_reverse, row_reverse, icon_only_display;
  logic       icon_blink_enable, ok;
  logic [7:0] wr_data, i2c_byte, rd_data, s;
  logic [6:0] address_counter, display_shift;
  int         fail_count, check_count;

  lcd_host_model i_lcd_host_model (.clk, .wr_ready, .wr_valid,
    .register_select, .wr_data, .i2c_byte_valid, .i2c_byte, .i2c_start,
    .rd_req, .rd_select, .rd_data, .rd_valid);

  lcd_instruction_decoder #(.DEPTH(8)) i_lcd_instruction_decoder (.clk,
    .reset, .wr_valid, .register_select, .wr_data, .wr_ready,
    .i2c_byte_valid, .i2c_byte, .i2c_start, .rd_req, .rd_select, .rd_data,
    .rd_valid, .busy_flag, .address_counter, .interface_width_select,
    .two_line_mode, .multiplex_ratio_select, .extended_page,
    .increment_dir, .shift_on_access, .display_on, .cursor_on,
    .cursor_blink, .power_down, .display_shift, .icon_only_display,
    .icon_blink_enable, .temp_coefficient_low, .temp_coefficient_high,
    .pump_stage_high, .pump_stage_low, .mirror_screen, .column_reverse,
    .row_reverse, .voltage_select_b(), .voltage_preset_a(),
    .voltage_preset_b());

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Issue a byte and measure how long busy stays high
  task automatic exec(input logic rs, input logic [7:0] d, input int t);
    int k;
    i_lcd_host_model.put(rs, d);
    k = 0;
    while (busy_flag !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (busy_flag === 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk("busy cycles", t[7:0], k[7:0]);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #160000;
    fail_count++;
    wrap_up();
  end

  initial begin
    reset = 1'b1;
    repeat (16) @(negedge clk);
    chk("busy in reset", 8'h01, {7'h00, busy_flag});
    chk("reset state", 8'hf0, {interface_width_select, increment_dir,
        power_down, pump_stage_high, pump_stage_low, display_on,
        extended_page, two_line_mode});
    reset = 1'b0;
    i_lcd_host_model.poll_idle();
    exec(1'b0, 8'h26, 3);
    chk("function set", 8'h06, {interface_width_select, two_line_mode,
        multiplex_ratio_select, extended_page});
    exec(1'b0, 8'h00, 3);
    chk("after nop", 8'h06, {interface_width_select, two_line_mode,
        multiplex_ratio_select, extended_page});
    i_lcd_host_model.put(1'b0, 8'h0c);
    i_lcd_host_model.put(1'b0, 8'h0f);
    i_lcd_host_model.read(1'b0, s, ok);
    chk("status busy", 8'h01, {7'h00, s[7]});
    chk("status valid", 8'h01, {7'h00, ok});
    i_lcd_host_model.poll_idle();
    chk("display on", 8'h08, {display_on, cursor_on, cursor_blink,
        power_down});
    exec(1'b0, 8'h08, 3);
    chk("display off", 8'h01, {display_on, cursor_on, cursor_blink,
        power_down});
    exec(1'b0, 8'hc0, 3);
    exec(1'b0, 8'h43, 3);
    i_lcd_host_model.read(1'b0, s, ok);
    chk("status addr", 8'h43, s);
    exec(1'b0, 8'h90, 3);
    exec(1'b1, 8'ha5, 3);
    chk("addr up", 8'h11, {1'b0, address_counter});
    exec(1'b0, 8'h04, 3);
    chk("entry dec", 8'h00, {increment_dir, shift_on_access});
    exec(1'b1, 8'h5a, 3);
    chk("addr down", 8'h10, {1'b0, address_counter});
    i_lcd_host_model.read(1'b1, s, ok);
    chk("read data", 8'ha5, s);
    exec(1'b0, 8'h14, 3);
    chk("cursor move", 8'h11, {1'b0, address_counter});
    exec(1'b0, 8'h1c, 3);
    chk("display shift", 8'h11, {1'b0, address_counter});
    i_lcd_host_model.read(1'b1, s, ok);
    chk("ram kept", 8'h5a, s);
    exec(1'b0, 8'h02, 3);
    chk("home", 8'h00, {address_counter, increment_dir});
    chk("home shift", 8'h00, {1'b0, display_shift});
    exec(1'b0, 8'h01, 165);
    chk("clear", 8'h01, {address_counter, increment_dir});
    exec(1'b0, 8'h80, 3);
    i_lcd_host_model.read(1'b1, s, ok);
    chk("blank zero", BLANK_CHAR, s);
    exec(1'b0, 8'h90, 3);
    i_lcd_host_model.read(1'b1, s, ok);
    chk("blank", BLANK_CHAR, s);
    exec(1'b0, 8'h07, 3);
    chk("entry inc", 8'h03, {increment_dir, shift_on_access});
    exec(1'b0, 8'h31, 3);
    chk("ext page", 8'h01, {7'h00, extended_page});
    exec(1'b0, 8'h05, 3);
    exec(1'b0, 8'h0a, 3);
    exec(1'b0, 8'h42, 3);
    exec(1'b0, 8'h45, 3);
    chk("ext cfg", 8'h69, {1'b0, mirror_screen, column_reverse,
        row_reverse, temp_coefficient_low, temp_coefficient_high,
        pump_stage_high, pump_stage_low});
    exec(1'b0, 8'h0e, 3);
    chk("icon", 8'h03, {icon_only_display, icon_blink_enable});
    exec(1'b0, 8'h30, 3);
    i_lcd_host_model.i2c_begin();
    i_lcd_host_model.i2c_cmd(1'b1, 1'b0, 8'ha0);
    i_lcd_host_model.poll_idle();
    i_lcd_host_model.i2c_cmd(1'b0, 1'b1, 8'h77);
    i_lcd_host_model.poll_idle();
    i_lcd_host_model.i2c_put(8'h66);
    i_lcd_host_model.poll_idle();
    chk("i2c addr", 8'h22, {1'b0, address_counter});
    exec(1'b0, 8'ha1, 3);
    i_lcd_host_model.read(1'b1, s, ok);
    chk("i2c data", 8'h66, s);
    chk("wr ready", 8'h01, {7'h00, wr_ready});
    i_lcd_host_model.put(1'b1, 8'h3c);
    i_lcd_host_model.put(1'b0, 8'h31);
    i_lcd_host_model.poll_idle();
    chk("dropped set", 8'h00, {7'h00, extended_page});
    chk("burst addr", 8'h22, {1'b0, address_counter});
    exec(1'b0, 8'ha1, 3);
    i_lcd_host_model.read(1'b1, s, ok);
    chk("burst data", 8'h3c, s);
    wrap_up();
  end
endmodule

// >>> verilog/lcd_cmd_fifo.sv
// Parameterised valid/ready FIFO for incoming host bytes
module lcd_cmd_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// >>> verilog/lcd_decoder_pkg.sv
// Shared constants for the character LCD instruction decoder
package lcd_decoder_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned EXEC_CYCLES     = 3;
  localparam int unsigned CLEAR_CYCLES    = 165;
  localparam int unsigned CNT_W           = 8;
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned GLYPH_LOW_W     = 6;
  localparam int unsigned FIFO_DEPTH      = 8;
  localparam int unsigned FIFO_WIDTH      = 9;
  localparam logic [7:0]  BLANK_CHAR      = 8'h20;
  localparam int unsigned TEXT_RAM_WORDS  = 128;
  localparam int unsigned GLYPH_RAM_WORDS = 128;
  // Field positions of function set
  localparam int unsigned FS_WIDTH_BIT    = 4;
  localparam int unsigned FS_LINES_BIT    = 2;
  localparam int unsigned FS_MUX_BIT      = 1;
  localparam int unsigned FS_PAGE_BIT     = 0;
  // Field positions of the I2C control byte
  localparam int unsigned CTRL_MORE_BIT   = 7;
  localparam int unsigned CTRL_RS_BIT     = 6;
  // Reset values
  localparam logic        RST_DIR_INC     = 1'b1;
  localparam logic        RST_WIDTH       = 1'b1;
  localparam logic [1:0]  RST_PUMP_STAGE  = 2'h2;
endpackage

// >>> verilog/lcd_instruction_decoder.sv
// Instruction decoder and execution sequencer of the LCD controller
module lcd_instruction_decoder
  import lcd_decoder_pkg::*;
#(
  parameter int unsigned DEPTH = lcd_decoder_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_valid,
  input  wire logic       register_select,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  input  wire logic       i2c_byte_valid,
  input  wire logic [7:0] i2c_byte,
  input  wire logic       i2c_start,
  input  wire logic       rd_req,
  input  wire logic       rd_select,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            busy_flag,
  output logic [6:0]      address_counter,
  output logic            interface_width_select,
  output logic            two_line_mode,
  output logic            multiplex_ratio_select,
  output logic            extended_page,
  output logic            increment_dir,
  output logic            shift_on_access,
  output logic            display_on,
  output logic            cursor_on,
  output logic            cursor_blink,
  output logic            power_down,
  output logic [6:0]      display_shift,
  output logic            icon_only_display,
  output logic            icon_blink_enable,
  output logic            temp_coefficient_low,
  output logic            temp_coefficient_high,
  output logic            pump_stage_high,
  output logic            pump_stage_low,
  output logic            mirror_screen,
  output logic            column_reverse,
  output logic            row_reverse,
  output logic            voltage_select_b,
  output logic [6:0]      voltage_preset_a,
  output logic [6:0]      voltage_preset_b
);
  import lcd_decoder_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} exec_state_e;

  exec_state_e      state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [7:0]       text_ram [TEXT_RAM_WORDS];
  logic [7:0]       glyph_ram [GLYPH_RAM_WORDS];
  logic             glyph_sel_ff;
  logic             i2c_ctrl_phase_ff;
  logic             i2c_rs_ff;
  logic             i2c_last_ff;
  logic             i2c_push;
  logic [8:0]       fifo_in;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic [8:0]       fifo_out;
  logic             fifo_out_valid;
  logic             fifo_take;
  logic             cmd_rs;
  logic [7:0]       cmd;
  logic [6:0]       step_addr;

  // I2C framing: control byte then payload byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      i2c_ctrl_phase_ff <= 1'b1;
      i2c_rs_ff         <= 1'b0;
      i2c_last_ff       <= 1'b0;
    end else if (i2c_start) begin
      i2c_ctrl_phase_ff <= 1'b1;
      i2c_last_ff       <= 1'b0;
    end else if (i2c_byte_valid && i2c_ctrl_phase_ff && !i2c_last_ff) begin
      i2c_rs_ff         <= i2c_byte[CTRL_RS_BIT];
      i2c_last_ff       <= !i2c_byte[CTRL_MORE_BIT];
      i2c_ctrl_phase_ff <= 1'b0;
    end else if (i2c_byte_valid && !i2c_ctrl_phase_ff) begin
      i2c_ctrl_phase_ff <= !i2c_last_ff;
    end
  end

  assign i2c_push      = i2c_byte_valid && !i2c_ctrl_phase_ff;
  assign fifo_in_valid = wr_valid || i2c_push;
  assign fifo_in       = wr_valid ? {register_select, wr_data}
                                  : {i2c_rs_ff, i2c_byte};

  lcd_cmd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   (fifo_in),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ready <= 1'b0;
    end else begin
      wr_ready <= fifo_in_ready;
    end
  end

  // Holding registers feed execution; writes during busy dropped
  assign cmd_rs    = fifo_out[8];
  assign cmd       = fifo_out[7:0];
  assign fifo_take = fifo_out_valid;
  assign step_addr = increment_dir ? address_counter + 7'h01
                                   : address_counter - 7'h01;

  logic accept;
  assign accept = fifo_take && (state_ff == ST_IDLE);

  // Busy sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff  <= ST_CLEAR;
      cnt_ff    <= CNT_W'(CLEAR_CYCLES);
      busy_flag <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (accept) begin
            busy_flag <= 1'b1;
            if (!cmd_rs && !extended_page && cmd == 8'h01) begin
              state_ff <= ST_CLEAR;
              cnt_ff   <= CNT_W'(CLEAR_CYCLES);
            end else begin
              state_ff <= ST_EXEC;
              cnt_ff   <= CNT_W'(EXEC_CYCLES);
            end
          end
        end
        ST_EXEC, ST_CLEAR: begin
          if (cnt_ff == CNT_W'(1)) begin
            state_ff  <= ST_IDLE;
            busy_flag <= 1'b0;
          end
          cnt_ff <= cnt_ff - 1'b1;
        end
        default: begin
          state_ff  <= ST_IDLE;
          busy_flag <= 1'b0;
        end
      endcase
    end
  end

  // Clear fills the text RAM over the busy window
  always_ff @(posedge clk) begin
    if (state_ff == ST_CLEAR && cnt_ff <= CNT_W'(TEXT_RAM_WORDS)) begin
      text_ram[ADDR_W'(cnt_ff - 1'b1)] <= BLANK_CHAR;
    end else if (accept && cmd_rs && !glyph_sel_ff) begin
      text_ram[address_counter] <= cmd;
    end
  end

  always_ff @(posedge clk) begin
    if (accept && cmd_rs && glyph_sel_ff) begin
      glyph_ram[address_counter] <= cmd;
    end
  end

  // Address counter and RAM selection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      address_counter <= '0;
      glyph_sel_ff    <= 1'b0;
      display_shift   <= '0;
      increment_dir   <= RST_DIR_INC;
      shift_on_access <= 1'b0;
    end else if (accept && cmd_rs) begin
      address_counter <= step_addr;
      if (shift_on_access) begin
        display_shift <= increment_dir ? display_shift + 7'h01
                                       : display_shift - 7'h01;
      end
    end else if (accept) begin
      if (cmd[7] && !extended_page) begin
        address_counter <= cmd[6:0];
        glyph_sel_ff    <= 1'b0;
      end else if (!extended_page) begin
        if (cmd[6]) begin
          address_counter[GLYPH_LOW_W-1:0] <= cmd[5:0];
          glyph_sel_ff <= 1'b1;
        end else if (cmd[7:4] == 4'h1) begin
          if (cmd[3]) begin
            display_shift <= cmd[2] ? display_shift + 7'h01
                                    : display_shift - 7'h01;
          end else begin
            address_counter <= cmd[2] ? address_counter + 7'h01
                                      : address_counter - 7'h01;
          end
        end else if (cmd[7:2] == 6'h01) begin
          increment_dir   <= cmd[1];
          shift_on_access <= cmd[0];
        end else if (cmd == 8'h02) begin
          address_counter <= '0;
          glyph_sel_ff    <= 1'b0;
          display_shift   <= '0;
        end else if (cmd == 8'h01) begin
          address_counter <= '0;
          glyph_sel_ff    <= 1'b0;
          display_shift   <= '0;
          increment_dir   <= 1'b1;
        end
      end
    end
  end

  // Status and data reads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req && !rd_select) begin
        rd_data <= {busy_flag, address_counter};
      end else if (rd_req) begin
        rd_data <= glyph_sel_ff ? glyph_ram[address_counter]
                                : text_ram[address_counter];
      end
    end
  end

  // Function set, display control and extended-page latches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interface_width_select <= RST_WIDTH;
      two_line_mode          <= 1'b0;
      multiplex_ratio_select <= 1'b0;
      extended_page          <= 1'b0;
      display_on             <= 1'b0;
      cursor_on              <= 1'b0;
      cursor_blink           <= 1'b0;
      power_down             <= 1'b1;
      icon_only_display      <= 1'b0;
      icon_blink_enable      <= 1'b0;
      temp_coefficient_low   <= 1'b0;
      temp_coefficient_high  <= 1'b0;
      {pump_stage_high, pump_stage_low} <= RST_PUMP_STAGE;
      mirror_screen          <= 1'b0;
      column_reverse         <= 1'b0;
      row_reverse            <= 1'b0;
      voltage_select_b       <= 1'b0;
      voltage_preset_a       <= '0;
      voltage_preset_b       <= '0;
    end else if (accept && !cmd_rs) begin
      if (cmd[7:5] == 3'h1) begin
        interface_width_select <= cmd[FS_WIDTH_BIT];
        two_line_mode          <= cmd[FS_LINES_BIT];
        multiplex_ratio_select <= cmd[FS_MUX_BIT];
        extended_page          <= cmd[FS_PAGE_BIT];
      end else if (!extended_page && cmd[7:3] == 5'h01) begin
        display_on   <= cmd[2];
        cursor_on    <= cmd[1];
        cursor_blink <= cmd[0];
        power_down   <= !cmd[2];
      end else if (extended_page) begin
        if (cmd[7:2] == 6'h01) begin
          mirror_screen <= cmd[0];
        end else if (cmd[7:2] == 6'h02) begin
          column_reverse <= cmd[1];
          row_reverse    <= cmd[0];
        end else if (cmd[7:2] == 6'h04 && cmd[0] == 1'b0) begin
          icon_only_display <= cmd[1];
          icon_blink_enable <= cmd[0];
        end else if (cmd[7:3] == 5'h01) begin
          icon_only_display <= cmd[2];
          icon_blink_enable <= cmd[1];
        end else if (cmd[7:2] == 6'h10) begin
          temp_coefficient_low  <= cmd[1];
          temp_coefficient_high <= cmd[0];
        end else if (cmd[7:2] == 6'h11) begin
          pump_stage_high <= cmd[1];
          pump_stage_low  <= cmd[0];
        end else if (cmd[7]) begin
          voltage_select_b <= cmd[6];
          if (cmd[6]) begin
            voltage_preset_b <= cmd[6:0];
          end else begin
            voltage_preset_a <= cmd[6:0];
          end
        end
      end
    end
  end

  // Checks
  property p_busy_exec;
    @(posedge clk) disable iff (reset)
      (state_ff == ST_IDLE && accept && !(cmd == 8'h01 && !cmd_rs
        && !extended_page)) |=> busy_flag [*3] ##1 !busy_flag;
  endproperty
  a_busy_exec: assert property (p_busy_exec) else $error("exec busy");

  property p_ignore_busy;
    @(posedge clk) disable iff (reset)
      (busy_flag && fifo_take && cmd[7:5] == 3'h1 && !cmd_rs)
        |=> $stable(extended_page);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("busy cmd");

  property p_status;
    @(posedge clk) disable iff (reset)
      (rd_req && !rd_select) |=> rd_data == {$past(busy_flag),
                                 $past(address_counter)};
  endproperty
  a_status: assert property (p_status) else $error("status read");

  property p_step;
    @(posedge clk) disable iff (reset)
      (accept && cmd_rs && increment_dir)
        |=> address_counter == $past(address_counter) + 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("address step");

  property p_func;
    @(posedge clk) disable iff (reset)
      (accept && !cmd_rs && cmd[7:5] == 3'h1)
        |=> extended_page == $past(cmd[0]);
  endproperty
  a_func: assert property (p_func) else $error("function set");

  property p_clear;
    @(posedge clk) disable iff (reset)
      (accept && !cmd_rs && !extended_page && cmd == 8'h01)
        |=> address_counter == 7'h00 ##[165:165] !busy_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear length");

  property p_pdown;
    @(posedge clk) disable iff (reset) power_down == !display_on;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down");

  property p_home;
    @(posedge clk) disable iff (reset)
      (accept && !cmd_rs && !extended_page && cmd == 8'h02)
        |=> address_counter == 7'h00 && display_shift == 7'h00;
  endproperty
  a_home: assert property (p_home) else $error("return home");

  c_write: cover property (@(posedge clk) accept && cmd_rs);
  c_clear: cover property (@(posedge clk) state_ff == ST_CLEAR);
  c_drop:  cover property (@(posedge clk) busy_flag && fifo_take);
endmodule
